// >>> rtl/sdram_pkg.sv
// Purpose: Shared constants for the SDRAM pin link, device end and controller end
// Assumes: 16-bit data variant, 200 MHz clock
// Notes: Commands are encoded as {ras_n, cas_n, we_n}
package sdram_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int AP_BIT = 10;
   // Mode key fields
   localparam int BL_LSB = 0;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int WB_BIT = 9;
   localparam logic [2:0] CL_TWO = 3'h2;
   localparam logic [2:0] CL_THREE = 3'h3;
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
   localparam logic [ADDR_W-1:0] CTRL_MODE_KEY = 12'h030;
   localparam int CTRL_CL = 3;
   // Commands
   localparam logic [2:0] CMD_MRW = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_STOP = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Storage model size
   localparam int MEM_AW = 8;
   localparam int MEM_DEPTH = 256;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS = 20;
   localparam int T_RC_NS = 65;
   localparam int T_WR_CYC = 2;
   localparam int T_MRD_CYC = 2;
   localparam int REFRESH_MS = 64;
   localparam int REFRESH_ROWS = 4096;
   localparam int INIT_WAIT_CYC = 8;
   localparam int WAIT_W = 4;
   localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFI_CYC = (REFRESH_MS * 1000000) / (REFRESH_ROWS * CLK_PERIOD_NS);
endpackage

// >>> rtl/sdram_link.sv
// Purpose: Pin bundle between controller and SDRAM device
// Assumes: Both ends on the same clock
// Notes: The shared data bus is resolved here per byte lane
`timescale 1ns/1ps
interface sdram_link;
   import sdram_pkg::*;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [BANK_W-1:0] bank_select;
   logic [ADDR_W-1:0] mux_address;
   logic lower_byte_mask;
   logic upper_byte_mask;
   logic [DATA_W-1:0] ctrl_dq;
   logic [1:0] ctrl_oe;
   logic [DATA_W-1:0] dev_dq;
   logic [1:0] dev_oe;
   wire [DATA_W-1:0] data_bus;
   for (genvar g = 0; g < 2; g++) begin : lane
      // An undriven lane reads as all ones, as pull-ups would hold it
      assign data_bus[8*g +: 8] = dev_oe[g] ? dev_dq[8*g +: 8] : (ctrl_oe[g] ? ctrl_dq[8*g +: 8] : 8'hFF);
   end
   modport device(input cke, cs_n, ras_n, cas_n, we_n, bank_select, mux_address,
      lower_byte_mask, upper_byte_mask, data_bus, output dev_dq, dev_oe);
   modport controller(output cke, cs_n, ras_n, cas_n, we_n, bank_select, mux_address,
      lower_byte_mask, upper_byte_mask, ctrl_dq, ctrl_oe, input data_bus);
endinterface

// >>> rtl/sdram_device_end.sv
// Purpose: Pin-level behaviour of a four-bank synchronous DRAM with a small storage array
// Assumes: Single clock shared with the controller; rstn stands in for power-up
// Notes: Storage holds 2 row bits and 4 column bits per bank, so addresses alias
//
// Functional notes
// - Inputs act only on rising clock edges
// - Chip select off ignores all but clock, enable, masks
// - Clock enable low freezes state next cycle
// - Controller raises enable a cycle before commands
// - Idle with enable low enters power-down
// - Row twelve bits, column bits 0-9 and 11
// - Bank select taken with row and column
// - Row strobe low latches row address
// - Column strobe low latches column, starts access
// - Write data captured from the write command cycle
// - Mask floats read output, drops write data
// - Sixteen-bit part has lower and upper masks
// - Shared data bus, never two drivers
// - Mode key sets latency, burst length, order
// - Burst reads with single-word writes mode
// - Controller refreshes 4096 rows every 64 ms
// - A data word may move every cycle
// - Mode write only with all banks closed
// - Two cycles after mode write before next
// - Refresh only with all banks closed
// - Both bank bits low select bank zero
`timescale 1ns/1ps
module sdram_device_end
   import sdram_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   sdram_link.device link,
   output logic power_down,
   output logic self_refresh,
   output logic [NUM_BANKS-1:0] bank_open,
   output logic [ADDR_W-1:0] mode_key
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   // Storage is small on purpose: just enough locations to tell banks, rows and columns apart
   logic cke_q;
   logic [1:0] dqm_q;
   logic sref_q;
   logic [ADDR_W-1:0] mode_q;
   logic [NUM_BANKS-1:0] open_q;
   logic [ADDR_W-1:0] row_q [NUM_BANKS];
   logic [3:0] left_q;
   logic [2:0] idx_q;
   logic [ADDR_W-1:0] base_q;
   logic [BANK_W-1:0] bbank_q;
   logic bwr_q;
   logic [2:0] pv_q;
   logic [DATA_W-1:0] pd_q [3];
   logic [DATA_W-1:0] mem [MEM_DEPTH];

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode
   // Enable is judged by its level at the previous edge, so a low enable masks the next edge
   wire cmd_v = cke_q & ~link.cs_n & ~sref_q;
   wire [2:0] cmd = {link.ras_n, link.cas_n, link.we_n};
   wire [BANK_W-1:0] bank = link.bank_select;
   wire [ADDR_W-1:0] addr = link.mux_address;
   wire is_act = cmd_v && (cmd == CMD_ACT);
   wire is_pre = cmd_v && (cmd == CMD_PRE);
   wire is_rd = cmd_v && (cmd == CMD_RD);
   wire is_wr = cmd_v && (cmd == CMD_WR);
   wire is_ref = cmd_v && (cmd == CMD_REF);
   // A mode write with any bank open is dropped rather than half applied
   wire is_mrw = cmd_v && (cmd == CMD_MRW) && (open_q == '0);
   wire is_stop = cmd_v && (cmd == CMD_STOP);
   // Column commands to a closed bank are ignored
   wire col_cmd = (is_rd | is_wr) & open_q[bank];

   ////////////////////////////////////////////////////////////////////////////////
   // Mode fields and burst addressing
   wire [2:0] bl_code = mode_q[BL_LSB +: 3];
   wire [3:0] blen = 4'h1 << bl_code[1:0];
   wire [2:0] lmask = 3'(blen - 4'h1);
   wire single_wr = mode_q[WB_BIT];
   wire [2:0] cl = mode_q[CL_LSB +: 3];
   wire [1:0] tap = (cl == CL_THREE) ? 2'h2 : 2'h1;
   wire [3:0] first_left = (is_wr && single_wr) ? 4'h0 : 4'(blen - 4'h1);
   wire [2:0] step = col_cmd ? 3'h0 : idx_q;
   wire [ADDR_W-1:0] cbase = col_cmd ? addr : base_q;
   wire [BANK_W-1:0] abank = col_cmd ? bank : bbank_q;
   wire awr = col_cmd ? is_wr : bwr_q;
   wire acc_v = col_cmd | (left_q != 4'h0);
   wire [2:0] off = mode_q[BT_BIT] ? (cbase[2:0] ^ step) : 3'(cbase[2:0] + step);
   wire [2:0] ccol = (cbase[2:0] & ~lmask) | (off & lmask);
   wire [ADDR_W-1:0] arow = row_q[abank];
   // Column bit ten is the auto-close flag, never part of the location
   wire [MEM_AW-1:0] aidx = {abank, arow[1:0], cbase[3], ccol};
   wire [1:0] wmask = {link.upper_byte_mask, link.lower_byte_mask};

   ////////////////////////////////////////////////////////////////////////////////
   // Unfrozen pin sampling: enable, masks and self refresh exit keep working
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cke_q <= 1'b0;
         dqm_q <= 2'h3;
         sref_q <= 1'b0;
      end else begin
         cke_q <= link.cke;
         dqm_q <= wmask;
         if (is_ref && !link.cke) begin
            sref_q <= 1'b1;
         end else if (sref_q && link.cke) begin
            sref_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_q <= MODE_RESET;
      end else if (is_mrw) begin
         mode_q <= addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-bank row state
   for (genvar b = 0; b < NUM_BANKS; b++) begin : bank_gen
      wire hit = (bank == BANK_W'(b));
      always_ff @(posedge clk) begin
         if (!rstn) begin
            open_q[b] <= 1'b0;
            row_q[b] <= '0;
         end else if (is_act && hit) begin
            open_q[b] <= 1'b1;
            row_q[b] <= addr;
         end else if ((is_pre && (hit || addr[AP_BIT])) || (col_cmd && hit && addr[AP_BIT])) begin
            open_q[b] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Burst sequencer: a new column command cuts any burst in progress
   always_ff @(posedge clk) begin
      if (!rstn) begin
         left_q <= 4'h0;
         idx_q <= 3'h0;
         base_q <= '0;
         bbank_q <= '0;
         bwr_q <= 1'b0;
      end else if (cke_q) begin
         if (col_cmd) begin
            left_q <= first_left;
            idx_q <= 3'h1;
            base_q <= addr;
            bbank_q <= bank;
            bwr_q <= is_wr;
         end else if (is_stop) begin
            left_q <= 4'h0;
         end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
            idx_q <= idx_q + 3'h1;
         end
      end
   end

   // Masked bytes are dropped; unmasked ones land in the same cycle
   always_ff @(posedge clk) begin
      if (cke_q && acc_v && awr) begin
         for (int g = 0; g < 2; g++) begin
            if (!wmask[g]) begin
               mem[aidx][8*g +: 8] <= link.data_bus[8*g +: 8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read latency pipe
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pv_q <= 3'h0;
      end else if (cke_q) begin
         pv_q <= {pv_q[1:0], acc_v & ~awr};
      end
   end

   always_ff @(posedge clk) begin
      if (cke_q) begin
         pd_q[0] <= mem[aidx];
         pd_q[1] <= pd_q[0];
         pd_q[2] <= pd_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Drive only while read data is due, so the controller's write slot is never shared
   // Masks are registered, so a mask floats the word driven after the edge that sampled it
   assign link.dev_dq = pd_q[tap];
   assign link.dev_oe = {2{pv_q[tap]}} & ~dqm_q;
   assign power_down = ~cke_q & (open_q == '0) & ~sref_q;
   assign self_refresh = sref_q;
   assign bank_open = open_q;
   assign mode_key = mode_q;

endmodule

// >>> rtl/sdram_controller_end.sv
// Purpose: Simple SDRAM controller: init, refresh, single-word reads and writes
// Assumes: Burst length one, latency three, auto-close on every access
// Notes: Read data returns through a two-entry buffer; a full buffer blocks new reads
`timescale 1ns/1ps
module sdram_controller_end
   import sdram_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   sdram_link.controller link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [BANK_W-1:0] req_bank,
   input wire logic [ADDR_W-1:0] req_row,
   input wire logic [ADDR_W-1:0] req_col,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [1:0] req_mask,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [DATA_W-1:0] rsp_data,
   input wire logic pd_req,
   output logic init_done
);

   typedef enum logic [7:0] {
      ST_PRE = 8'h01, ST_REF = 8'h02, ST_MRW = 8'h04, ST_IDLE = 8'h08,
      ST_ACT = 8'h10, ST_COL = 8'h20, ST_WAIT = 8'h40, ST_PDN = 8'h80
   } ctrl_state_type;

   ctrl_state_type state_q, ret_q;
   logic [WAIT_W-1:0] wait_q;
   logic init_q, refn_q, due_q, cke_q, cs_n_q, wr_q;
   logic [2:0] cmd_q;
   logic [BANK_W-1:0] bank_q;
   logic [ADDR_W-1:0] addr_q, col_q;
   logic [1:0] mask_q, wmask_q, oe_q;
   logic [DATA_W-1:0] dq_q, wdata_q;
   logic [11:0] tmr_q;
   logic [3:0] rd_sh_q;
   logic [DATA_W-1:0] fifo_q [2];
   logic wp_q, rp_q;
   logic [1:0] cnt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Handshakes and refresh timing
   wire full = (cnt_q == 2'h2);
   wire take = req_valid & req_ready;
   wire push = rd_sh_q[CTRL_CL];
   wire pop = rsp_valid & rsp_ready;
   wire wrap = (tmr_q == 12'h0);
   wire in_idle = (state_q == ST_IDLE);
   assign req_ready = in_idle & ~due_q & (req_write | ~full);
   assign rsp_valid = (cnt_q != 2'h0);
   assign rsp_data = fifo_q[rp_q];
   assign init_done = init_q;
   assign link.cke = cke_q;
   assign link.cs_n = cs_n_q;
   assign {link.ras_n, link.cas_n, link.we_n} = cmd_q;
   assign link.bank_select = bank_q;
   assign link.mux_address = addr_q;
   assign {link.upper_byte_mask, link.lower_byte_mask} = mask_q;
   assign link.ctrl_dq = dq_q;
   assign link.ctrl_oe = oe_q;

   // A due refresh set by the timer wins over the clear by an issued refresh
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tmr_q <= 12'(REFI_CYC - 1);
         due_q <= 1'b0;
      end else begin
         tmr_q <= wrap ? 12'(REFI_CYC - 1) : 12'(tmr_q - 12'h1);
         due_q <= wrap | (due_q & (state_q != ST_REF));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: each wait of N places the next command N+1 cycles later
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_WAIT;
         ret_q <= ST_PRE;
         wait_q <= WAIT_W'(INIT_WAIT_CYC);
         init_q <= 1'b0;
         refn_q <= 1'b0;
         cke_q <= 1'b1;
         cs_n_q <= 1'b1;
         cmd_q <= CMD_NOP;
         bank_q <= '0;
         addr_q <= '0;
         mask_q <= 2'h0;
         oe_q <= 2'h0;
         dq_q <= '0;
         wr_q <= 1'b0;
         col_q <= '0;
         wdata_q <= '0;
         wmask_q <= 2'h0;
      end else begin
         cs_n_q <= 1'b1;
         cmd_q <= CMD_NOP;
         oe_q <= 2'h0;
         mask_q <= 2'h0;
         case (state_q)
            ST_WAIT: begin
               if (wait_q <= WAIT_W'(1)) begin
                  state_q <= ret_q;
               end else begin
                  wait_q <= wait_q - WAIT_W'(1);
               end
            end
            ST_PRE: begin
               cs_n_q <= 1'b0;
               cmd_q <= CMD_PRE;
               addr_q[AP_BIT] <= 1'b1;
               state_q <= ST_WAIT;
               wait_q <= WAIT_W'(T_RP_CYC - 1);
               ret_q <= ST_REF;
            end
            ST_REF: begin
               cs_n_q <= 1'b0;
               cmd_q <= CMD_REF;
               refn_q <= 1'b1;
               state_q <= ST_WAIT;
               wait_q <= WAIT_W'(T_RC_CYC - 1);
               ret_q <= init_q ? ST_IDLE : (refn_q ? ST_MRW : ST_REF);
            end
            ST_MRW: begin
               cs_n_q <= 1'b0;
               cmd_q <= CMD_MRW;
               addr_q <= CTRL_MODE_KEY;
               init_q <= 1'b1;
               state_q <= ST_WAIT;
               wait_q <= WAIT_W'(T_MRD_CYC - 1);
               ret_q <= ST_IDLE;
            end
            ST_IDLE: begin
               if (due_q) begin
                  state_q <= ST_REF;
               end else if (take) begin
                  cs_n_q <= 1'b0;
                  cmd_q <= CMD_ACT;
                  bank_q <= req_bank;
                  addr_q <= req_row;
                  wr_q <= req_write;
                  col_q <= req_col;
                  wdata_q <= req_wdata;
                  wmask_q <= req_mask;
                  state_q <= ST_WAIT;
                  wait_q <= WAIT_W'(T_RCD_CYC - 1);
                  ret_q <= ST_COL;
               end else if (pd_req) begin
                  cke_q <= 1'b0;
                  state_q <= ST_PDN;
               end
            end
            ST_PDN: begin
               if (!pd_req || due_q) begin
                  cke_q <= 1'b1;
                  state_q <= ST_WAIT;
                  wait_q <= WAIT_W'(1);
                  ret_q <= ST_IDLE;
               end
            end
            ST_COL: begin
               cs_n_q <= 1'b0;
               cmd_q <= wr_q ? CMD_WR : CMD_RD;
               addr_q <= {col_q[11], 1'b1, col_q[9:0]};
               if (wr_q) begin
                  oe_q <= 2'h3;
                  dq_q <= wdata_q;
                  mask_q <= wmask_q;
               end
               state_q <= ST_WAIT;
               wait_q <= wr_q ? WAIT_W'(T_WR_CYC + T_RP_CYC) : WAIT_W'(CTRL_CL + T_RP_CYC);
               ret_q <= ST_IDLE;
            end
            default: state_q <= ST_PRE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read return: two-entry buffer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_sh_q <= 4'h0;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         rd_sh_q <= {rd_sh_q[2:0], (state_q == ST_COL) & ~wr_q};
         wp_q <= wp_q ^ push;
         rp_q <= rp_q ^ pop;
         cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         fifo_q[wp_q] <= link.data_bus;
      end
   end

endmodule

// >>> verification/sdram_pin_command_interface_checker.sv
// Purpose: Concurrent checks on the pins between controller end and device end
// Assumes: Controller programs latency three, burst one, auto-close on every access
// Notes: Watches the interface signals only, instantiated beside the link
`timescale 1ns/1ps
module sdram_pin_command_interface_checker
   import sdram_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BANK_W-1:0] bank_select,
   input wire logic [ADDR_W-1:0] mux_address,
   input wire logic lower_byte_mask,
   input wire logic upper_byte_mask,
   input wire logic [1:0] ctrl_oe,
   input wire logic [1:0] dev_oe
);
   // A refresh may wait behind one access already in flight
   localparam int REF_SLACK = 16;
   wire [2:0] cmd = {ras_n, cas_n, we_n};
   wire issued = !cs_n && (cmd != CMD_NOP);
   wire col_cmd = issued && (cmd == CMD_RD || cmd == CMD_WR);
   logic [12:0] since_ref_q;
   logic [12:0] since_ref_d;
   assign since_ref_d = (issued && cmd == CMD_REF) ? 13'h0000 :
      since_ref_q + ((since_ref_q != 13'h1FFF) ? 13'h1 : 13'h0);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         since_ref_q <= 13'h0000;
      end else begin
         since_ref_q <= since_ref_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_bus_one_driver: assert property ((ctrl_oe & dev_oe) == 2'b00)
      else $error("both ends drive the data bus");
   chk_cmd_cke_ready: assert property (issued |-> cke && $past(cke))
      else $error("command without clock enable a cycle before");
   chk_col_after_act: assert property (col_cmd |-> mux_address[AP_BIT] &&
      $past(issued && cmd == CMD_ACT, 4) && $past(bank_select, 4) == bank_select)
      else $error("column command not tied to activation of its bank");
   chk_read_return: assert property (issued && cmd == CMD_RD |-> ##1 dev_oe == 2'b00
      ##1 dev_oe == 2'b00 ##1 dev_oe == ~$past({upper_byte_mask, lower_byte_mask}) ##1 dev_oe == 2'b00)
      else $error("read word not driven at latency three for one cycle");
   chk_write_drive: assert property (issued && cmd == CMD_WR |-> ctrl_oe == 2'b11 ##1 ctrl_oe == 2'b00)
      else $error("write data not driven in the write command cycle only");
   chk_mode_key: assert property (issued && cmd == CMD_MRW |-> mux_address == CTRL_MODE_KEY)
      else $error("unexpected mode key");
   chk_mode_gap: assert property (issued && cmd == CMD_MRW |=> !issued)
      else $error("command too soon after mode write");
   chk_reset_quiet: assert property ($rose(rstn) |-> dev_oe == 2'b00 && ctrl_oe == 2'b00 && cs_n)
      else $error("bus or select active after reset");
   chk_freeze_oe: assert property (!$past(cke) |-> $stable(dev_oe))
      else $error("device output moved while clock masked");
   chk_refresh_gap: assert property (since_ref_q <= REFI_CYC + REF_SLACK)
      else $error("refresh interval exceeded");
endmodule

// >>> verification/sdram_pin_command_interface_tb.sv
// Purpose: Both link ends joined, user side of the controller driven and scored
// Assumes: Storage index {bank, row[1:0], col[3:0]}, other address bits alias
// Notes: Reads are unmasked; masked bytes are tried on writes
`timescale 1ns/1ps
module sdram_pin_command_interface_tb;
   import sdram_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   logic req_write = 1'b0;
   logic [BANK_W-1:0] req_bank = '0;
   logic [ADDR_W-1:0] req_row = '0;
   logic [ADDR_W-1:0] req_col = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic [1:0] req_mask = '0;
   logic rsp_valid;
   logic rsp_ready = 1'b1;
   logic [DATA_W-1:0] rsp_data;
   logic pd_req = 1'b0;
   logic init_done;
   logic power_down;
   logic self_refresh;
   logic [NUM_BANKS-1:0] bank_open;
   logic [ADDR_W-1:0] mode_key;
   logic stall = 1'b0;
   int fails = 0;
   int samples_checked = 0;
   int seed = 32'h64153E66;
   int cyc = 0;
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] rd_q [$];
   logic [29:0] pin_q [$];
   wire [29:0] pin_seen = {sdram_link_i.bank_select, sdram_link_i.mux_address,
      sdram_link_i.we_n ? 16'h0000 : sdram_link_i.data_bus};
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   sdram_link sdram_link_i ();
   sdram_device_end sdram_device_end_i (.clk(clk), .rstn(rstn), .link(sdram_link_i), .power_down(power_down),
      .self_refresh(self_refresh), .bank_open(bank_open), .mode_key(mode_key));
   sdram_controller_end sdram_controller_end_i (.clk(clk), .rstn(rstn), .link(sdram_link_i), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
      .req_wdata(req_wdata), .req_mask(req_mask), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_data(rsp_data), .pd_req(pd_req), .init_done(init_done));
   sdram_pin_command_interface_checker sdram_pin_command_interface_checker_i (.clk(clk), .rstn(rstn),
      .cke(sdram_link_i.cke), .cs_n(sdram_link_i.cs_n), .ras_n(sdram_link_i.ras_n), .cas_n(sdram_link_i.cas_n),
      .we_n(sdram_link_i.we_n), .bank_select(sdram_link_i.bank_select), .mux_address(sdram_link_i.mux_address),
      .lower_byte_mask(sdram_link_i.lower_byte_mask), .upper_byte_mask(sdram_link_i.upper_byte_mask),
      .ctrl_oe(sdram_link_i.ctrl_oe), .dev_oe(sdram_link_i.dev_oe));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("samples_checked=%0d fails=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Upper row and column bits are random so aliasing and bit ten are exercised
   task automatic do_req(input logic wr, input logic [7:0] idx, input logic [1:0] mask);
      int n;
      logic [DATA_W-1:0] d;
      logic [ADDR_W-1:0] col;
      n = 0;
      d = 16'($random(seed));
      col = 12'($random(seed));
      col[3:0] = idx[3:0];
      @(negedge clk);
      req_write = wr;
      req_bank = idx[7:6];
      req_row = 12'($random(seed));
      req_row[1:0] = idx[5:4];
      req_col = col;
      req_wdata = d;
      req_mask = mask;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check(req_ready, 32'h1);
      @(posedge clk);
      pin_q.push_back({idx[7:6], col[11], 1'b1, col[9:0], wr ? d : 16'h0000});
      if (wr) begin
         if (!mask[0]) mem[idx][7:0] = d[7:0];
         if (!mask[1]) mem[idx][15:8] = d[15:8];
      end else begin
         rd_q.push_back(mem[idx]);
      end
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////
   // Receiver stalls one cycle in three, or fully while the buffer is being filled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      rsp_ready <= !stall && (cyc % 3 != 0);
   end
   always @(posedge clk) begin
      if (rstn && !sdram_link_i.cs_n && sdram_link_i.ras_n && !sdram_link_i.cas_n) begin
         check(pin_seen, pin_q.size() ? pin_q.pop_front() : 32'hFFFFFFFF);
      end
   end
   always @(posedge clk) begin
      if (rstn && rsp_valid === 1'b1 && rsp_ready) begin
         check(rsp_data, rd_q.size() ? rd_q.pop_front() : 32'hFFFFFFFF);
      end
   end
   initial begin
      #(CLK_PERIOD_NS * 40000);
      fails++;
      close_out();
   end
   initial begin
      int n;
      int i;
      logic [31:0] r;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      check(mode_key, MODE_RESET);
      check(bank_open, 32'h0);
      for (n = 0; n < 200 && init_done !== 1'b1; n++) @(negedge clk);
      // The device takes the key one edge after the controller flags init done
      @(negedge clk);
      check(init_done, 32'h1);
      check(mode_key, CTRL_MODE_KEY);
      for (i = 0; i < MEM_DEPTH; i++) do_req(1'b1, i[7:0], 2'b00);
      for (i = 0; i < 150; i++) begin
         r = $random(seed);
         do_req(r[0], r[15:8], r[0] ? r[3:2] : 2'b00);
      end
      // Drain reads in flight first, or the stalled buffer fills one word early
      for (n = 0; n < 100 && rd_q.size() != 0; n++) @(negedge clk);
      stall <= 1'b1;
      do_req(1'b0, 8'h00, 2'b00);
      do_req(1'b0, 8'hFF, 2'b00);
      repeat (15) @(negedge clk);
      check(req_ready, 32'h0);
      stall <= 1'b0;
      do_req(1'b0, 8'h5A, 2'b00);
      pd_req = 1'b1;
      repeat (20) @(negedge clk);
      check(sdram_link_i.cke, 32'h0);
      check(power_down, 32'h1);
      check(self_refresh, 32'h0);
      pd_req = 1'b0;
      for (i = 0; i < 40; i++) begin
         r = $random(seed);
         do_req(r[0], r[15:8], r[0] ? r[3:2] : 2'b00);
      end
      for (n = 0; n < 100 && rd_q.size() != 0; n++) @(negedge clk);
      check(rd_q.size(), 32'h0);
      check(bank_open, 32'h0);
      close_out();
   end
endmodule
